// ==== core/itam_map.vh ====
// Constants of the interval tick and activity monitor block.
// Assumes one 125 MHz clock; included by bare name by every design file.
// Contract
// (RULE_01) Phase clock pulses go through a divide-by-four, then three cascaded decade counters.
// (RULE_02) Each interval tick sets the interval flag, once per 1000 machine cycles.
// (RULE_03) The interval chain keeps counting, never paused or reloaded, while the flag is set.
// (RULE_04) The interval flag clears only on the CPU acknowledge of the interval interrupt.
// (RULE_05) Ticks advance the two monitor decade counters only while the arm flip-flop is set.
// (RULE_06) The second monitor decade carry feeds two final stages; the last raises the alarm.
// (RULE_07) Software must run the arm instruction first; no alarm before that. The code also arms on a power-fail edge, which can raise the alarm.
// (RULE_08) Each arm instruction restarts the monitor; 200,000 idle machine cycles raise alarm and stall.
// (RULE_09) Power fail sets arm and preloads counters to expire in 100 machine cycles, then stall.
// (RULE_10) The interval flag clear comes from the priority interrupt logic beside the console clear.
// (RULE_11) The alarm state drives a console operating indicator lamp.
// (RULE_12) Reset clears counters, interval flag, arm flip-flop and alarm stages; monitor disarmed.
`ifndef ITAM_MAP_VH
`define ITAM_MAP_VH

// Counter geometry
`define ITAM_DIG_W 4
`define ITAM_PRE_MAX 4'h3
`define ITAM_DEC_MAX 4'h9
`define ITAM_ZERO 4'h0

// Power-fail preload: interval chain at 900 of 1000, monitor at 99 with stage one set
`define ITAM_PF_PRE 4'h0
`define ITAM_PF_INT_ONES 4'h0
`define ITAM_PF_INT_TENS 4'h0
`define ITAM_PF_INT_HUND 4'h9
`define ITAM_PF_MON_ONES 4'h9
`define ITAM_PF_MON_TENS 4'h9

// Priority interrupt levels for acknowledge decode
`define ITAM_LVL_W 3
`define ITAM_LVL_INTERVAL 3'h6
`define ITAM_LVL_CONSOLE 3'h7

// Register bus
`define ITAM_ADDR_W 3
`define ITAM_DATA_W 8
`define ITAM_REG_STATUS 3'h0
`define ITAM_REG_CLEAR 3'h1
`define ITAM_REG_ENABLE 3'h2
`define ITAM_REG_STATE 3'h3
`define ITAM_REG_MONCNT 3'h4
`define ITAM_REG_INTCNT 3'h5
`define ITAM_RD_ZERO 8'h00

// Interrupt event bits
`define ITAM_EV_W 3
`define ITAM_EV_TICK 0
`define ITAM_EV_ALARM 1
`define ITAM_EV_PFAIL 2
`define ITAM_EV_ZERO 3'h0

// State register bits
`define ITAM_ST_FLAG 0
`define ITAM_ST_ARM 1
`define ITAM_ST_STAGE1 2
`define ITAM_ST_ALARM 3

`endif

// ==== core/itam_digit.v ====
// One modulo counter digit with synchronous load and clear.
// Assumes step, load and clear are one-cycle levels in the clk domain.
`timescale 1ns/1ps
`include "itam_map.vh"
module itam_digit
#(
   parameter [3:0] MAXV = `ITAM_DEC_MAX
)
(
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Control
   input wire step,
   input wire clear,
   input wire load,
   input wire [3:0] load_val,
   // Status
   output wire [3:0] value,
   output wire carry
);
   reg [3:0] count_ff;
   reg [3:0] nxt_count;

   assign value = count_ff;
   // Carry is combinational so a whole chain rolls over in one cycle
   assign carry = step & (count_ff == MAXV);

   // Load beats clear beats step
   always @*
   begin
      nxt_count = count_ff;
      if (load)
         nxt_count = load_val;
      else if (clear)
         nxt_count = `ITAM_ZERO;
      else if (carry)
         nxt_count = `ITAM_ZERO;
      else if (step)
         nxt_count = count_ff + 4'h1;
   end

   // Counter state
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         count_ff <= `ITAM_ZERO;
      else
         count_ff <= nxt_count;
   end
endmodule

// ==== core/itam_irq.v ====
// Sticky interrupt status with enable mask and write-one-to-clear.
// Assumes write strobes are single cycles from the register decode.
`timescale 1ns/1ps
`include "itam_map.vh"
module itam_irq
(
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Events
   input wire [2:0] events,
   // Software access
   input wire clear_wr,
   input wire enable_wr,
   input wire [2:0] wdata,
   // Results
   output wire [2:0] status,
   output wire [2:0] enable,
   output wire irq
);
   reg [2:0] status_ff;
   reg [2:0] enable_ff;
   reg [2:0] nxt_status;

   assign status = status_ff;
   assign enable = enable_ff;
   assign irq = |(status_ff & enable_ff);

   // Set wins over clear so an event in the clearing cycle is kept
   always @*
   begin
      nxt_status = status_ff;
      if (clear_wr)
         nxt_status = nxt_status & ~wdata;
      nxt_status = nxt_status | events;
   end

   // Status and mask
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         status_ff <= `ITAM_EV_ZERO;
         enable_ff <= `ITAM_EV_ZERO;
      end
      else
      begin
         status_ff <= nxt_status;
         if (enable_wr)
            enable_ff <= wdata;
      end
   end
endmodule

// ==== core/itam_top.v ====
// Interval tick generator, interval interrupt flag and activity monitor.
// Assumes phase_one_clock is a one-cycle pulse per processor phase, four per
// machine cycle, and that CPU-side strobes are synchronous single-cycle pulses.
// The register port never stalls; read data stands one cycle after the strobe.
// The monitor stays disarmed out of reset until an arm instruction or a power fail.
`timescale 1ns/1ps
`include "itam_map.vh"
module itam_top
(
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Processor timing
   input wire phase_one_clock,
   // CPU instruction sequencer
   input wire monitor_arm_instruction,
   input wire power_fail,
   // Priority interrupt acknowledge
   input wire intr_ack,
   input wire [2:0] ack_level,
   // Register port
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output wire [7:0] reg_rdata,
   // Interval outputs
   output wire interval_tick_pulse,
   output wire interval_flag,
   output wire interval_flag_clear,
   output wire console_flag_clear,
   // Monitor outputs
   output wire activity_monitor_alarm,
   output wire cpu_stall,
   output wire alarm_lamp,
   // Interrupt to software
   output wire irq
);
   // Interval chain wires
   wire [3:0] pre_val;
   wire [3:0] int_ones;
   wire [3:0] int_tens;
   wire [3:0] int_hund;
   wire pre_carry;
   wire ones_carry;
   wire tens_carry;
   wire tick;
   // Tick is combinational; interval_tick_pulse is its registered copy

   // Monitor chain wires
   wire [3:0] mon_ones;
   wire [3:0] mon_tens;
   wire mon_step;
   wire mon_ones_carry;
   // Carry out of the second monitor decade, one per 100 armed ticks
   wire mon_carry;

   // Power-fail edge and interrupt wires
   wire pf_edge;
   wire [2:0] irq_status;
   wire [2:0] irq_enable;
   wire [2:0] events;
   wire clear_wr;
   wire enable_wr;

   // State flops
   reg flag_ff;
   reg arm_ff;
   reg stage1_ff;
   reg alarm_ff;
   reg pf_last_ff;
   reg tick_ff;
   reg flag_clear_ff;
   reg console_clear_ff;
   reg [7:0] rdata_ff;

   // Next values
   reg nxt_flag;
   reg nxt_arm;
   reg nxt_stage1;
   reg nxt_alarm;
   reg [7:0] nxt_rdata;
   // One-cycle strobe for the status bit, not a flip-flop
   reg alarm_event;

   // Level decode used for both acknowledge clears
   // Shared so that a level change cannot affect one clear and not the other
   function ack_match;
      input ack;
      input [2:0] level;
      input [2:0] want;
      begin
         ack_match = ack & (level == want);
      end
   endfunction

   // Power fail is taken on its rising edge only, so a held level preloads once
   // The previous-level flop clears in reset, so a level already high at release
   // still preloads once on the first edge
   assign pf_edge = power_fail & ~pf_last_ff;

   // Each digit's carry is combinational, so the whole chain rolls over on one
   // edge and the tick lands in the cycle of the 4000th phase pulse
   // Divide-by-four prescaler on the phase clock; never reloaded by the flag [RULE_01] [RULE_03]
   itam_digit #(.MAXV(`ITAM_PRE_MAX)) u_pre
   (
      .clk(clk),
      .resetn(resetn),
      .step(phase_one_clock),
      .clear(1'b0),
      .load(pf_edge),
      .load_val(`ITAM_PF_PRE),
      .value(pre_val),
      .carry(pre_carry)
   );

   // First interval decade [RULE_01]
   itam_digit #(.MAXV(`ITAM_DEC_MAX)) u_int_ones
   (
      .clk(clk),
      .resetn(resetn),
      .step(pre_carry),
      .clear(1'b0),
      .load(pf_edge),
      .load_val(`ITAM_PF_INT_ONES),
      .value(int_ones),
      .carry(ones_carry)
   );

   // Second interval decade [RULE_01]
   // Rolls over only on the ones carry, within the same cycle
   itam_digit #(.MAXV(`ITAM_DEC_MAX)) u_int_tens
   (
      .clk(clk),
      .resetn(resetn),
      .step(ones_carry),
      .clear(1'b0),
      .load(pf_edge),
      .load_val(`ITAM_PF_INT_TENS),
      .value(int_tens),
      .carry(tens_carry)
   );

   // Loaded to nine on power fail, leaving 400 phase pulses to the next tick
   // Third interval decade; its carry is the interval tick [RULE_01] [RULE_09]
   itam_digit #(.MAXV(`ITAM_DEC_MAX)) u_int_hund
   (
      .clk(clk),
      .resetn(resetn),
      .step(tens_carry),
      .clear(1'b0),
      .load(pf_edge),
      .load_val(`ITAM_PF_INT_HUND),
      .value(int_hund),
      .carry(tick)
   );

   // Gating the step rather than the clock keeps one clock domain; an unarmed
   // monitor sits at zero and can never carry into the alarm stages
   // Monitor counts ticks only while armed [RULE_05] [RULE_07]
   assign mon_step = tick & arm_ff;

   // Clear beats step, so a re-arm in a tick cycle still restarts from zero
   // and the count never includes that tick
   // First monitor decade; an arm instruction restarts it [RULE_08]
   itam_digit #(.MAXV(`ITAM_DEC_MAX)) u_mon_ones
   (
      .clk(clk),
      .resetn(resetn),
      .step(mon_step),
      .clear(monitor_arm_instruction),
      .load(pf_edge),
      .load_val(`ITAM_PF_MON_ONES),
      .value(mon_ones),
      .carry(mon_ones_carry)
   );

   // Second monitor decade [RULE_05] [RULE_08]
   // Its carry feeds the two alarm stages
   itam_digit #(.MAXV(`ITAM_DEC_MAX)) u_mon_tens
   (
      .clk(clk),
      .resetn(resetn),
      .step(mon_ones_carry),
      .clear(monitor_arm_instruction),
      .load(pf_edge),
      .load_val(`ITAM_PF_MON_TENS),
      .value(mon_tens),
      .carry(mon_carry)
   );

   // The clear is registered, so the flag drops two cycles after the
   // acknowledge; the interrupt stays visible through the whole entry
   // Interval flag: tick sets it, only the interval acknowledge clears it [RULE_02] [RULE_04]
   always @*
   begin
      nxt_flag = flag_ff;
      if (flag_clear_ff)
         nxt_flag = 1'b0;
      // A tick in the clearing cycle wins
      if (tick)
         nxt_flag = 1'b1;
   end

   // Arm flip-flop and final alarm stages
   always @*
   begin
      nxt_arm = arm_ff;
      nxt_stage1 = stage1_ff;
      nxt_alarm = alarm_ff;
      alarm_event = 1'b0;
      // Priority: power fail, then arm instruction, then the monitor carry.
      // Power fail beats arm so that an arm instruction in the same
      // cycle as the power-fail edge cannot cancel the preload.
      if (pf_edge)
      begin
         // Preload so the next tick carries into the last stage [RULE_09]
         nxt_arm = 1'b1;
         nxt_stage1 = 1'b1;
         nxt_alarm = 1'b0;
      end
      else if (monitor_arm_instruction)
      begin
         // Re-arm restarts the whole timeout [RULE_08]
         nxt_arm = 1'b1;
         nxt_stage1 = 1'b0;
         nxt_alarm = 1'b0;
      end
      else if (mon_carry)
      begin
         // Two carries of 100 ticks each reach the alarm [RULE_06] [RULE_08]
         if (stage1_ff)
         begin
            nxt_alarm = 1'b1;
            alarm_event = ~alarm_ff;
         end
         nxt_stage1 = 1'b1;
      end
   end

   // Control state; reset leaves the monitor disarmed [RULE_12]
   // The reset branch loads constants only, so every flop clears together
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flag_ff <= 1'b0;
         arm_ff <= 1'b0;
         stage1_ff <= 1'b0;
         alarm_ff <= 1'b0;
         pf_last_ff <= 1'b0;
         tick_ff <= 1'b0;
      end
      else
      begin
         flag_ff <= nxt_flag;
         arm_ff <= nxt_arm;
         stage1_ff <= nxt_stage1;
         alarm_ff <= nxt_alarm;
         pf_last_ff <= power_fail;
         tick_ff <= tick;
      end
   end

   // Acknowledge decode for interval and console flags [RULE_10]
   // Registering the decode keeps the acknowledge path short; the one-cycle
   // delay is harmless because the flag holds until the clear pulse
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flag_clear_ff <= 1'b0;
         console_clear_ff <= 1'b0;
      end
      else
      begin
         flag_clear_ff <= ack_match(intr_ack, ack_level, `ITAM_LVL_INTERVAL); // [RULE_10]
         console_clear_ff <= ack_match(intr_ack, ack_level, `ITAM_LVL_CONSOLE);
      end
   end

   // Software interrupt events
   // Each event is a one-cycle pulse, so a status bit is set once per event;
   // the alarm event fires on the rising alarm only, not while it stands
   assign events = {pf_edge, alarm_event, tick};
   assign clear_wr = reg_write & (reg_addr == `ITAM_REG_CLEAR);
   assign enable_wr = reg_write & (reg_addr == `ITAM_REG_ENABLE);

   // Sticky status, mask and level interrupt line
   // Set wins over a software clear in the same cycle
   itam_irq u_irq
   (
      .clk(clk),
      .resetn(resetn),
      .events(events),
      .clear_wr(clear_wr),
      .enable_wr(enable_wr),
      .wdata(reg_wdata[2:0]),
      .status(irq_status),
      .enable(irq_enable),
      .irq(irq)
   );

   // Read mux; unmapped and write-only addresses read zero
   // Counter reads are a snapshot; the chain keeps running, so software
   // should treat the digits as approximate
   always @*
   begin
      nxt_rdata = `ITAM_RD_ZERO;
      if (reg_addr == `ITAM_REG_STATUS)
         nxt_rdata = {5'h00, irq_status};
      else if (reg_addr == `ITAM_REG_ENABLE)
         nxt_rdata = {5'h00, irq_enable};
      else if (reg_addr == `ITAM_REG_STATE)
         nxt_rdata = {4'h0, alarm_ff, stage1_ff, arm_ff, flag_ff};
      else if (reg_addr == `ITAM_REG_MONCNT)
         nxt_rdata = {mon_tens, mon_ones};
      else if (reg_addr == `ITAM_REG_INTCNT)
         nxt_rdata = {int_hund, int_tens};
   end

   // Read data stands only in the cycle after the strobe
   // Zero outside the answer cycle so a stale word never looks valid
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rdata_ff <= `ITAM_RD_ZERO;
      else if (reg_read)
         rdata_ff <= nxt_rdata;
      else
         rdata_ff <= `ITAM_RD_ZERO;
   end

   // Outputs
   // Alarm, stall and lamp share one flop so they can never disagree
   assign reg_rdata = rdata_ff;
   assign interval_tick_pulse = tick_ff;
   assign interval_flag = flag_ff;
   assign interval_flag_clear = flag_clear_ff;
   assign console_flag_clear = console_clear_ff;
   assign activity_monitor_alarm = alarm_ff;
   assign cpu_stall = alarm_ff; // Stall holds until re-arm, a power-fail edge or reset [RULE_08]
   assign alarm_lamp = alarm_ff; // [RULE_11]
endmodule

// ==== tb/itam_checker.sv ====
// Port assertions for itam_top, bound onto every instance of it.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module itam_checker
(
   // Clock, reset and inputs
   input wire clk,
   input wire resetn,
   input wire phase_one_clock,
   input wire monitor_arm_instruction,
   input wire power_fail,
   input wire intr_ack,
   input wire [2:0] ack_level,
   // Outputs watched
   input wire interval_tick_pulse,
   input wire interval_flag,
   input wire interval_flag_clear,
   input wire console_flag_clear,
   input wire activity_monitor_alarm,
   input wire cpu_stall,
   input wire alarm_lamp,
   input wire irq
);
   logic [12:0] ph_cnt_ff;
   logic pf_ff;
   logic armed_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Phase pulses per tick; a power-fail preload shortens one period, so ticks are skipped while power_fail is high and at the first tick after it falls
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ph_cnt_ff <= 13'h0;
         pf_ff <= 1'b0;
         armed_ff <= 1'b0;
      end
      else
      begin
         ph_cnt_ff <= (interval_tick_pulse ? 13'h0 : ph_cnt_ff) + {12'h0, phase_one_clock};
         pf_ff <= power_fail | (pf_ff & ~interval_tick_pulse);
         armed_ff <= armed_ff | monitor_arm_instruction | power_fail;
      end
   end
   tick_period_a: assert property (interval_tick_pulse && !pf_ff |-> ph_cnt_ff == 13'hfa0)
      else $error("tick period wrong");
   flag_rise_a: assert property ($rose(interval_flag) |-> interval_tick_pulse)
      else $error("flag set without tick");
   tick_single_a: assert property (interval_tick_pulse |-> interval_flag ##1 !interval_tick_pulse)
      else $error("tick pulse malformed");
   flag_hold_a: assert property (interval_flag && !interval_flag_clear |=> interval_flag)
      else $error("flag lost without clear");
   flag_drop_a: assert property (interval_flag_clear |=> !interval_flag || interval_tick_pulse)
      else $error("flag not cleared");
   ack_decode_a: assert property (intr_ack |=> interval_flag_clear == ($past(ack_level) == 3'h6)
      && console_flag_clear == ($past(ack_level) == 3'h7)) else $error("ack decode wrong");
   alarm_armed_a: assert property (activity_monitor_alarm |-> armed_ff)
      else $error("alarm while never armed");
   arm_restart_a: assert property (monitor_arm_instruction && !power_fail |=> !activity_monitor_alarm)
      else $error("arm did not restart");
   lamp_stall_a: assert property (alarm_lamp == activity_monitor_alarm && cpu_stall == activity_monitor_alarm)
      else $error("lamp or stall mismatch");
   reset_state_a: assert property ($rose(resetn) |-> !interval_flag && !activity_monitor_alarm && !irq)
      else $error("state after reset");
   cover property (interval_flag_clear);
   cover property (console_flag_clear);
   cover property ($rose(activity_monitor_alarm));
endmodule

bind itam_top itam_checker chk (.*);

// ==== tb/itam_cpu_model.sv ====
// Instruction sequencer and interrupt acknowledge side facing itam_top.
// Assumes task callers start right after a rising clock edge.
`timescale 1ns/1ps
module itam_cpu_model
(
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Toward the block
   output logic phase_one_clock,
   output logic monitor_arm_instruction,
   output logic intr_ack,
   output logic [2:0] ack_level
);
   initial
   begin
      monitor_arm_instruction = 1'b0;
      intr_ack = 1'b0;
      ack_level = 3'h0;
   end
   // Phase pulse every second clock, so a tick needs 8000 clocks
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         phase_one_clock <= 1'b0;
      else
         phase_one_clock <= ~phase_one_clock;
   end
   // Arm instruction, one cycle
   task automatic arm();
      monitor_arm_instruction <= 1'b1;
      @(posedge clk);
      monitor_arm_instruction <= 1'b0;
   endtask
   // Acknowledge; the level is scrambled once released
   task automatic ack(input logic [2:0] lvl);
      intr_ack <= 1'b1;
      ack_level <= lvl;
      @(posedge clk);
      intr_ack <= 1'b0;
      ack_level <= ~lvl;
   endtask
endmodule

// ==== tb/tb_itam_top.sv ====
// Self-checking bench for itam_top.
// Assumes the checker is bound by its own file and the CPU side is modelled.
`timescale 1ns/1ps
module tb_itam_top;
   logic clk, resetn, power_fail, reg_write, reg_read;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   wire [7:0] reg_rdata;
   wire phase_one_clock, monitor_arm_instruction, intr_ack, interval_tick_pulse, interval_flag;
   wire activity_monitor_alarm, irq;
   wire [2:0] ack_level;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;
   itam_top uut (.clk(clk), .resetn(resetn), .phase_one_clock(phase_one_clock),
      .monitor_arm_instruction(monitor_arm_instruction), .power_fail(power_fail), .intr_ack(intr_ack),
      .ack_level(ack_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .interval_tick_pulse(interval_tick_pulse),
      .interval_flag(interval_flag), .interval_flag_clear(), .console_flag_clear(),
      .activity_monitor_alarm(activity_monitor_alarm), .cpu_stall(), .alarm_lamp(), .irq(irq));
   itam_cpu_model cpu (.clk(clk), .resetn(resetn), .phase_one_clock(phase_one_clock),
      .monitor_arm_instruction(monitor_arm_instruction), .intr_ack(intr_ack), .ack_level(ack_level));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic final_report();
      if (fail_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 chk(nm, exp, reg_rdata);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   // Bounded wait for the next interval flag
   task automatic wait_flag();
      for (int i = 0; i < 9000 && interval_flag !== 1'b1; i++)
         @(negedge clk);
      chk("flag", 8'h01, {7'h0, interval_flag});
   endtask
   // Hang guard; the sequence needs about 17k cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fail_count++;
         final_report();
      end
   end
   initial
   begin
      resetn = 1'b0;
      power_fail = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rd(3'h3, 8'h00, "state");
      wr(3'h2, 8'h07);
      wait_flag();
      rd(3'h5, 8'h00, "intcnt");
      rd(3'h0, 8'h01, "status");
      chk("irq", 8'h01, {7'h0, irq});
      rd(3'h4, 8'h00, "moncnt_idle");
      repeat (2200) @(posedge clk);
      rd(3'h5, 8'h27, "intcnt_run");
      chk("flag_held", 8'h01, {7'h0, interval_flag});
      @(posedge clk);
      cpu.ack(3'h7);
      @(posedge clk);
      #1 chk("flag_console_ack", 8'h01, {7'h0, interval_flag});
      @(posedge clk);
      cpu.ack(3'h6);
      @(posedge clk);
      #1 chk("flag_ack", 8'h00, {7'h0, interval_flag});
      wr(3'h1, 8'h01);
      rd(3'h0, 8'h00, "status_clr");
      chk("irq_clr", 8'h00, {7'h0, irq});
      @(posedge clk);
      cpu.arm();
      rd(3'h3, 8'h02, "state_arm");
      wait_flag();
      rd(3'h4, 8'h01, "moncnt_step");
      @(posedge clk);
      cpu.arm();
      rd(3'h4, 8'h00, "moncnt_restart");
      @(posedge clk);
      cpu.ack(3'h6);
      wr(3'h2, 8'h00);
      #1 chk("flag_ack_again", 8'h00, {7'h0, interval_flag});
      @(posedge clk);
      power_fail <= 1'b1;
      rd(3'h3, 8'h06, "state_pf");
      n = 0;
      while (activity_monitor_alarm !== 1'b1 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      chk("pf_delay", 8'h01, {7'h0, n >= 785 && n <= 805});
      rd(3'h0, 8'h07, "status_pf");
      chk("irq_masked", 8'h00, {7'h0, irq});
      wr(3'h2, 8'h02);
      #1 chk("irq_alarm", 8'h01, {7'h0, irq});
      wr(3'h1, 8'h07);
      #1 chk("irq_cleared", 8'h00, {7'h0, irq});
      // Re-arm with power fail gone must drop a standing alarm
      @(posedge clk);
      power_fail <= 1'b0;
      cpu.arm();
      rd(3'h3, 8'h03, "state_rearm");
      chk("alarm_rearm", 8'h00, {7'h0, activity_monitor_alarm});
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      chk("alarm_rst", 8'h00, {7'h0, activity_monitor_alarm});
      chk("flag_rst", 8'h00, {7'h0, interval_flag});
      resetn <= 1'b1;
      rd(3'h3, 8'h00, "state_rst");
      rd(3'h6, 8'h00, "unmapped");
      final_report();
   end
endmodule
